// file: design/boundary_run_test_engine.sv
`timescale 1ns/1ps
// How it works
// - operation selector comes from run-test control register bits 2 to 0.
// - operation runs only with boundary-run instruction active in Run-Test/Idle.
// - X00 sample/toggle, X01 36-bit pattern, X10 36-bit signature.
// - 011 18-bit signature plus pattern, 111 18-bit signature plus count.
// - control cells 47 to 36 never altered by any run operation.
// - enable cells 47 to 44 decide which pins are driven or floating.
// - run only with one direction per byte, same for both; else bypass.
// - sample/toggle loads input-mode pin values into cells each rising edge.
// - sample/toggle inverts output cells on rise, latches and drives on fall.
// - 36-bit pattern steps on rise, output half latched and driven on fall.
// - an all-zero seed stays zero in pattern generation.
// - 36-bit signature folds input pin values into cells each rise.
// - 36-bit signature holds output shadows constant and keeps driving them.
// - combined modes fold input pins into an 18-bit signature.
// - signature-with-pattern steps an 18-bit generator on output cells.
// - signature-with-count increments an 18-bit count on output cells.
// - boundary-run puts bypass bit in path, capturing 0 at Capture-DR.
// - a pin is an output when its enable cell holds 0.
// - inputs sampled on rising tck, outputs change on falling tck.
module boundary_run_test_engine #(
  parameter logic [bist_pkg::IO_W-1:0] TAPS_WIDE =
    bist_pkg::TAPS_WIDE_DEFAULT,
  parameter logic [bist_pkg::HALF_W-1:0] TAPS_NARROW =
    bist_pkg::TAPS_NARROW_DEFAULT,
  parameter int STEP_COUNT_W = 16
) (
  // system side
  input wire logic clk,
  input wire logic rst,
  input wire logic snapshot_req,
  output bist_pkg::status_t status,
  output logic [STEP_COUNT_W-1:0] step_count,
  output logic [bist_pkg::IO_W-1:0] snapshot,
  output logic snapshot_done,
  // test access port
  input wire logic tck,
  input wire bist_pkg::tap_ctrl_t tap,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n,
  // i/o pins
  input wire logic [bist_pkg::IO_W-1:0] pin_in,
  output logic [bist_pkg::IO_W-1:0] pin_out,
  output logic [bist_pkg::IO_W-1:0] pin_oe_n
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the top tap bit must be set or the register is not a full-length lfsr
  generate
    if (!TAPS_WIDE[bist_pkg::IO_W-1] || !TAPS_NARROW[bist_pkg::HALF_W-1] ||
        STEP_COUNT_W < 1) begin : bad_params
      $error("feedback taps or step counter width unusable");
    end
  endgenerate

  // ****************************************
  // feedback and decode functions
  // ****************************************
  function automatic logic [bist_pkg::IO_W-1:0] step_wide(
    input logic [bist_pkg::IO_W-1:0] v);
    step_wide = {v[bist_pkg::IO_W-2:0], ^(v & TAPS_WIDE)};
  endfunction

  function automatic logic [bist_pkg::HALF_W-1:0] step_narrow(
    input logic [bist_pkg::HALF_W-1:0] v);
    step_narrow = {v[bist_pkg::HALF_W-2:0], ^(v & TAPS_NARROW)};
  endfunction

  function automatic bist_pkg::op_t decode_op(
    input logic [bist_pkg::OP_CODE_W-1:0] code);
    case (code[1:0])
      2'b00: decode_op = bist_pkg::OP_SAMPLE_TOGGLE;
      2'b01: decode_op = bist_pkg::OP_PATTERN;
      2'b10: decode_op = bist_pkg::OP_SIGNATURE;
      default: begin
        decode_op = code[2] ? bist_pkg::OP_SIG_COUNT :
                    bist_pkg::OP_SIG_PATTERN;
      end
    endcase
  endfunction

  // inputs sit on side a when data flows a to b, else on side b
  function automatic logic [bist_pkg::IO_W-1:0] place(
    input logic a_in, input logic [bist_pkg::HALF_W-1:0] in_half,
    input logic [bist_pkg::HALF_W-1:0] out_half);
    place = a_in ? {out_half, in_half} : {in_half, out_half};
  endfunction

  // ****************************************
  // tck domain state
  // ****************************************
  logic [bist_pkg::CHAIN_W-1:0] chain;
  logic [bist_pkg::CHAIN_W-1:0] shadow;
  logic [bist_pkg::OP_CODE_W-1:0] rtc;
  logic bypass;
  logic step_tgl;
  logic [bist_pkg::IO_W-1:0] snap_hold;
  logic snap_ack_tgl;
  logic snap_req_tgl;
  logic [bist_pkg::SYNC_STAGES-1:0] snap_req_sync;
  bist_pkg::status_t status_tck;

  // ****************************************
  // mode and direction decode
  // ****************************************
  wire e1ab = shadow[bist_pkg::OE_B1_AB];
  wire e1ba = shadow[bist_pkg::OE_B1_BA];
  wire e2ab = shadow[bist_pkg::OE_B2_AB];
  wire e2ba = shadow[bist_pkg::OE_B2_BA];
  wire dir_valid = (e1ab != e1ba) && (e2ab != e2ba) && (e1ab == e2ab);
  wire a_to_b = !e1ab;
  wire run_instr = tap.sel_run_test;
  wire run_active = run_instr && tap.run_test_idle && dir_valid;
  wire bypass_sel = !tap.sel_boundary && !tap.sel_rtc_scan;
  bist_pkg::op_t op;
  assign op = decode_op(rtc);

  wire [bist_pkg::HALF_W-1:0] in_cells =
    a_to_b ? chain[bist_pkg::B_LO-1:bist_pkg::A_LO] :
             chain[bist_pkg::CTRL_LO-1:bist_pkg::B_LO];
  wire [bist_pkg::HALF_W-1:0] out_cells =
    a_to_b ? chain[bist_pkg::CTRL_LO-1:bist_pkg::B_LO] :
             chain[bist_pkg::B_LO-1:bist_pkg::A_LO];
  wire [bist_pkg::HALF_W-1:0] in_pins =
    a_to_b ? pin_in[bist_pkg::B_LO-1:bist_pkg::A_LO] :
             pin_in[bist_pkg::CTRL_LO-1:bist_pkg::B_LO];
  wire [bist_pkg::IO_W-1:0] in_mask =
    place(a_to_b, bist_pkg::HALF_ONES, bist_pkg::HALF_ZERO);
  wire [bist_pkg::IO_W-1:0] io_cells = chain[bist_pkg::CTRL_LO-1:0];

  // ****************************************
  // next value of the i/o cells
  // ****************************************
  logic [bist_pkg::IO_W-1:0] next_io;
  always_comb begin
    case (op)
      bist_pkg::OP_SAMPLE_TOGGLE: begin
        next_io = place(a_to_b, in_pins, ~out_cells);
      end
      bist_pkg::OP_PATTERN: begin
        next_io = step_wide(io_cells);
      end
      bist_pkg::OP_SIGNATURE: begin
        next_io = step_wide(io_cells) ^ (in_mask & pin_in);
      end
      bist_pkg::OP_SIG_PATTERN: begin
        next_io = place(a_to_b, step_narrow(in_cells) ^ in_pins,
                        step_narrow(out_cells));
      end
      bist_pkg::OP_SIG_COUNT: begin
        next_io = place(a_to_b, step_narrow(in_cells) ^ in_pins,
                        out_cells + bist_pkg::COUNT_STEP);
      end
      default: begin
        next_io = io_cells;
      end
    endcase
  end

  // ****************************************
  // rising tck: chain, control register, bypass
  // ****************************************
  always_ff @(posedge tck) begin
    if (tap.test_logic_reset) begin
      chain <= bist_pkg::CHAIN_RESET;
    end else if (tap.shift_dr && tap.sel_boundary) begin
      chain <= {tdi, chain[bist_pkg::CHAIN_W-1:1]};
    end else if (tap.capture_dr && tap.sel_boundary) begin
      chain <= {chain[bist_pkg::CHAIN_W-1:bist_pkg::CTRL_LO], pin_in};
    end else if (run_active) begin
      chain <= {chain[bist_pkg::CHAIN_W-1:bist_pkg::CTRL_LO], next_io};
    end
  end

  // only its own scan or a tap reset changes it, so repeated runs reuse it
  always_ff @(posedge tck) begin
    if (tap.test_logic_reset) begin
      rtc <= bist_pkg::RTC_RESET;
    end else if (tap.shift_dr && tap.sel_rtc_scan) begin
      rtc <= {tdi, rtc[bist_pkg::OP_CODE_W-1:1]};
    end
  end

  always_ff @(posedge tck) begin
    if (tap.test_logic_reset) begin
      bypass <= 1'b0;
    end else if (tap.capture_dr && bypass_sel) begin
      bypass <= 1'b0;
    end else if (tap.shift_dr && bypass_sel) begin
      bypass <= tdi;
    end
  end

  // ****************************************
  // rising tck: status and snapshot toward clk
  // ****************************************
  always_ff @(posedge tck) begin
    if (tap.test_logic_reset) begin
      step_tgl <= 1'b0;
      status_tck <= '{running: 1'b0, refused: 1'b0,
                      op: bist_pkg::OP_SAMPLE_TOGGLE};
    end else begin
      if (run_active) begin
        step_tgl <= ~step_tgl;
      end
      status_tck <= '{running: run_active,
                      refused: run_instr && !dir_valid, op: op};
    end
  end

  // request arrives as a toggle; tck must run for it to be answered
  wire snap_req_seen = snap_req_sync[2] != snap_req_sync[1];
  always_ff @(posedge tck) begin
    if (tap.test_logic_reset) begin
      snap_req_sync <= '0;
      snap_ack_tgl <= 1'b0;
      snap_hold <= '0;
    end else begin
      snap_req_sync <= {snap_req_sync[1:0], snap_req_tgl};
      if (snap_req_seen) begin
        snap_hold <= io_cells;
        snap_ack_tgl <= ~snap_ack_tgl;
      end
    end
  end

  // ****************************************
  // falling tck: shadow latches, pins, tdo
  // ****************************************
  wire [bist_pkg::IO_W-1:0] out_mask = ~in_mask;
  wire shadow_follow = run_active && (op != bist_pkg::OP_SIGNATURE);
  logic [bist_pkg::CHAIN_W-1:0] next_shadow;
  always_comb begin
    next_shadow = shadow;
    if (tap.update_dr && tap.sel_boundary) begin
      next_shadow = chain;
    end else if (shadow_follow) begin
      next_shadow[bist_pkg::CTRL_LO-1:0] = (io_cells & out_mask) |
        (shadow[bist_pkg::CTRL_LO-1:0] & in_mask);
    end
  end

  wire test_drive = run_instr && dir_valid;
  wire [bist_pkg::IO_W-1:0] drive;
  genvar i;
  generate
    for (i = 0; i < bist_pkg::IO_W; i++) begin : pin_dir
      localparam int EN_BIT = (i < bist_pkg::B_LO) ?
        ((i < bist_pkg::B_LO / 2) ? bist_pkg::OE_B1_BA : bist_pkg::OE_B2_BA) :
        ((i < bist_pkg::B_LO + bist_pkg::B_LO / 2) ? bist_pkg::OE_B1_AB :
         bist_pkg::OE_B2_AB);
      assign drive[i] = test_drive && !next_shadow[EN_BIT];
    end
  endgenerate

  always_ff @(negedge tck) begin
    if (tap.test_logic_reset) begin
      shadow <= bist_pkg::CHAIN_RESET;
      pin_oe_n <= '1;
    end else begin
      shadow <= next_shadow;
      pin_oe_n <= ~drive;
    end
  end
  assign pin_out = shadow[bist_pkg::CTRL_LO-1:0];

  always_ff @(negedge tck) begin
    if (tap.test_logic_reset) begin
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else begin
      tdo <= tap.sel_boundary ? chain[0] :
             tap.sel_rtc_scan ? rtc[0] : bypass;
      tdo_oe_n <= !tap.shift_dr;
    end
  end

  // ****************************************
  // clk domain: crossings and counters
  // ****************************************
  bist_pkg::status_t [bist_pkg::SYNC_STAGES-1:0] status_sync;
  logic [bist_pkg::SYNC_STAGES-1:0] step_sync;
  logic [bist_pkg::SYNC_STAGES-1:0] ack_sync;
  // request toggle is declared with the tck state it feeds
  logic snap_busy;
  // status is taken once stages two and three agree; a toggle counts when they differ
  wire status_stable = status_sync[2] == status_sync[1];
  wire step_seen = step_sync[2] != step_sync[1];
  wire ack_seen = ack_sync[2] != ack_sync[1];

  always_ff @(posedge clk) begin
    if (rst) begin
      status_sync <= '0;
      step_sync <= '0;
      ack_sync <= '0;
    end else begin
      status_sync <= {status_sync[1:0], status_tck};
      step_sync <= {step_sync[1:0], step_tgl};
      ack_sync <= {ack_sync[1:0], snap_ack_tgl};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status <= '{running: 1'b0, refused: 1'b0,
                  op: bist_pkg::OP_SAMPLE_TOGGLE};
      step_count <= '0;
    end else begin
      if (status_stable) begin
        status <= status_sync[2];
      end
      if (step_seen) begin
        step_count <= step_count + 1'b1;
      end
    end
  end

  // one request in flight; a request while busy is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      snap_req_tgl <= 1'b0;
      snap_busy <= 1'b0;
      snapshot_done <= 1'b0;
      snapshot <= '0;
    end else begin
      snapshot_done <= ack_seen;
      if (snapshot_req && !snap_busy) begin
        snap_req_tgl <= ~snap_req_tgl;
        snap_busy <= 1'b1;
      end else if (ack_seen) begin
        snap_busy <= 1'b0;
      end
      if (ack_seen) begin
        snapshot <= snap_hold;
      end
    end
  end

endmodule // boundary_run_test_engine

// file: design/bist_pkg.sv
package bist_pkg;

  // ****************************************
  // chain geometry
  // ****************************************
  localparam int CHAIN_W = 48;
  localparam int IO_W = 36;
  localparam int HALF_W = 18;
  localparam int A_LO = 0;
  localparam int B_LO = 18;
  localparam int CTRL_LO = 36;
  localparam int OE_B1_AB = 47;
  localparam int OE_B1_BA = 46;
  localparam int OE_B2_AB = 45;
  localparam int OE_B2_BA = 44;
  localparam int OP_CODE_W = 3;
  localparam int SYNC_STAGES = 3;

  // ****************************************
  // reset values and default feedback
  // ****************************************
  // enables inactive (high) so nothing drives after reset
  localparam logic [CHAIN_W-1:0] CHAIN_RESET = 48'hf00000000000;
  localparam logic [OP_CODE_W-1:0] RTC_RESET = 3'h0;
  // x^36 + x^25 + 1 and x^18 + x^11 + 1
  localparam logic [IO_W-1:0] TAPS_WIDE_DEFAULT = 36'h801000000;
  localparam logic [HALF_W-1:0] TAPS_NARROW_DEFAULT = 18'h20400;
  localparam logic [HALF_W-1:0] HALF_ONES = 18'h3ffff;
  localparam logic [HALF_W-1:0] HALF_ZERO = 18'h00000;
  localparam logic [HALF_W-1:0] COUNT_STEP = 18'h00001;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    OP_SAMPLE_TOGGLE = 3'b000,
    OP_PATTERN = 3'b001,
    OP_SIGNATURE = 3'b010,
    OP_SIG_PATTERN = 3'b011,
    OP_SIG_COUNT = 3'b100
  } op_t;

  typedef struct packed {
    logic test_logic_reset;
    logic run_test_idle;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic sel_run_test;
    logic sel_rtc_scan;
    logic sel_boundary;
  } tap_ctrl_t;

  typedef struct packed {
    logic running;
    logic refused;
    op_t op;
  } status_t;

endpackage

// file: design/_fix_note_unused.sv
`timescale 1ns/1ps

// file: bench/run_engine_properties.sv
`timescale 1ns/1ps
module run_engine_properties #(
  parameter int STEP_COUNT_W = 16
) (
  // clocks and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic tck,
  // watched outputs and tap levels
  input wire bist_pkg::status_t status,
  input wire logic [STEP_COUNT_W-1:0] step_count,
  input wire bist_pkg::tap_ctrl_t tap,
  input wire logic tdo,
  input wire logic tdo_oe_n,
  input wire logic [bist_pkg::IO_W-1:0] pin_out,
  input wire logic [bist_pkg::IO_W-1:0] pin_oe_n
);
  // ****************************************
  // tck domain
  // ****************************************
  property p_outside_hiz;
    @(posedge tck) disable iff (tap.test_logic_reset)
    !$past(tap.sel_run_test) |-> &pin_oe_n;
  endproperty
  a_outside_hiz: assert property (p_outside_hiz)
    else $error("pins driven outside the run instruction");
  property p_tlr_quiet;
    @(posedge tck) disable iff (tap.test_logic_reset)
    $past(tap.test_logic_reset) |-> (&pin_oe_n) && tdo_oe_n;
  endproperty
  a_tlr_quiet: assert property (p_tlr_quiet)
    else $error("drivers active right after tap reset");
  property p_one_side;
    @(posedge tck) disable iff (tap.test_logic_reset)
    (&pin_oe_n[17:0]) || (&pin_oe_n[35:18]);
  endproperty
  a_one_side: assert property (p_one_side)
    else $error("both port sides driven at once");
  // one enable per byte and direction, never per pin
  property p_byte_uniform;
    @(posedge tck) disable iff (tap.test_logic_reset)
    pin_oe_n == {{9{pin_oe_n[27]}}, {9{pin_oe_n[18]}},
      {9{pin_oe_n[9]}}, {9{pin_oe_n[0]}}};
  endproperty
  a_byte_uniform: assert property (p_byte_uniform)
    else $error("pin enables split inside a byte");
  // ****************************************
  // clk domain
  // ****************************************
  // clk and tck edges never coincide in the bench, so this is exact
  property p_fall_only;
    @(posedge clk) disable iff (rst)
    ($changed(pin_out) || $changed(pin_oe_n) || $changed(tdo)) |-> !tck;
  endproperty
  a_fall_only: assert property (p_fall_only)
    else $error("pin or tdo changed after a rising tck");
  sequence s_sig_busy;
    (status.running && status.op == bist_pkg::OP_SIGNATURE) [*2];
  endsequence
  property p_sig_hold;
    @(posedge clk) disable iff (rst)
    s_sig_busy |-> $stable(pin_out);
  endproperty
  a_sig_hold: assert property (p_sig_hold)
    else $error("output latches moved during wide signature");
  property p_excl;
    @(posedge clk) disable iff (rst)
    !(status.running && status.refused);
  endproperty
  a_excl: assert property (p_excl)
    else $error("running and refused together");
  property p_step;
    @(posedge clk) disable iff (rst)
    $changed(step_count) |->
      step_count - $past(step_count) == STEP_COUNT_W'(1);
  endproperty
  a_step: assert property (p_step)
    else $error("step count jumped");
endmodule // run_engine_properties

bind boundary_run_test_engine run_engine_properties #(
  .STEP_COUNT_W(STEP_COUNT_W)
) u_props (
  .clk(clk), .rst(rst), .tck(tck), .status(status),
  .step_count(step_count), .tap(tap), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n)
);

// file: bench/tap_ctrl_model.sv
`timescale 1ns/1ps
module tap_ctrl_model (
  // controller side of the test access port
  output logic tck,
  output bist_pkg::tap_ctrl_t tap,
  output logic tdi
);
  initial begin
    tck = 1'b0;
    tap = 8'h80;
    tdi = 1'b0;
    #7;
    forever #24 tck = ~tck;
  end
  // levels move only after a falling tck, non-blocking to dodge races
  task automatic reset_tap();
    repeat (2) @(negedge tck);
    tap.test_logic_reset <= 1'b0;
  endtask
  // seed or opcode goes in before any run, lsb first
  task automatic scan(input logic [47:0] v, input int n,
    input logic chain);
    for (int i = 0; i < n; i++) begin
      @(negedge tck);
      tap.sel_boundary <= chain;
      tap.sel_rtc_scan <= !chain;
      tap.shift_dr <= 1'b1;
      tdi <= v[i];
    end
    @(negedge tck);
    tap.shift_dr <= 1'b0;
    tap.update_dr <= 1'b1;
    @(negedge tck);
    tap.update_dr <= 1'b0;
    tap.sel_boundary <= 1'b0;
    tap.sel_rtc_scan <= 1'b0;
  endtask
  task automatic run(input int k);
    @(negedge tck);
    tap.sel_run_test <= 1'b1;
    tap.run_test_idle <= 1'b1;
    repeat (k) @(negedge tck);
    tap.sel_run_test <= 1'b0;
    tap.run_test_idle <= 1'b0;
  endtask
endmodule // tap_ctrl_model

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, rst, snapshot_req, tck, tdi, tdo, tdo_oe_n, snapshot_done;
  bist_pkg::status_t status;
  bist_pkg::tap_ctrl_t tap;
  logic [15:0] step_count;
  logic [35:0] snapshot, pin_in, pin_out, pin_oe_n;
  logic [71:0] exp_q[$];
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  int seed = 83498;
  int total = 0;
  boundary_run_test_engine u_dut (
    .clk(clk), .rst(rst), .snapshot_req(snapshot_req), .status(status),
    .step_count(step_count), .snapshot(snapshot),
    .snapshot_done(snapshot_done), .tck(tck), .tap(tap), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n)
  );
  tap_ctrl_model u_tap (.tck(tck), .tap(tap), .tdi(tdi));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [71:0] e,
    input logic [71:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one step of the selected operation, a_to_b so inputs are cells 17..0
  function automatic logic [35:0] nx(logic [2:0] c, logic [35:0] s,
    logic [17:0] p);
    logic [35:0] w;
    logic [17:0] lo, hi;
    w = {s[34:0], ^(s & bist_pkg::TAPS_WIDE_DEFAULT)};
    lo = {s[16:0], ^(s[17:0] & bist_pkg::TAPS_NARROW_DEFAULT)} ^ p;
    hi = c[2] ? s[35:18] + 18'h00001 :
      {s[34:18], ^(s[35:18] & bist_pkg::TAPS_NARROW_DEFAULT)};
    case (c[1:0])
      2'h0: nx = {~s[35:18], p};
      2'h1: nx = w;
      2'h2: nx = w ^ {18'h00000, p};
      default: nx = {hi, lo};
    endcase
  endfunction
  // ****************************************
  // result watcher
  // ****************************************
  always @(posedge clk) begin
    cycles++;
    if (snapshot_done === 1'b1 && exp_q.size() != 0)
      chk("cells_and_pins", exp_q.pop_front(), {pin_out, snapshot});
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    logic [35:0] s, cur;
    logic [17:0] p;
    logic [2:0] c;
    int k;
    rst = 1'b1;
    snapshot_req = 1'b0;
    pin_in = 36'h000000000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    u_tap.reset_tap();
    // 0..7 every code, 8 zero seed, 9 split directions, 10 reuse code
    for (int i = 0; i < 11; i++) begin
      c = (i >= 9) ? 3'h2 : (i == 8) ? 3'h1 : i[2:0];
      k = 3 + i % 2;
      s = (i == 8) ? 36'h000000000 : 36'({$random(seed), $random(seed)});
      p = 18'($random(seed));
      @(posedge clk);
      pin_in <= {18'($random(seed)), p};
      if (i != 10) u_tap.scan({45'h0, c}, 3, 1'b0);
      u_tap.scan({(i == 9) ? 4'h6 : 4'h5, 8'h00, s}, 48, 1'b1);
      cur = s;
      if (i != 9) begin
        for (int j = 0; j < k; j++) cur = nx(c, cur, p);
        total += k;
      end
      exp_q.push_back({(c[1:0] == 2'h2) ? s[35:18] : cur[35:18],
        s[17:0], cur});
      fork
        u_tap.run(k);
        begin
          repeat (3) @(negedge tck);
          #1 chk("pin_oe_n", {36'h0, (i == 9) ? 36'hfffffffff : 36'h00003ffff}, {36'h0, pin_oe_n});
        end
      join
      @(posedge clk);
      snapshot_req <= 1'b1;
      @(posedge clk);
      snapshot_req <= 1'b0;
      for (int w = 0; w < 80 && exp_q.size() != 0; w++) @(posedge clk);
      if (exp_q.size() != 0) begin
        chk("snapshot_done", 72'h1, 72'h0);
        exp_q.delete();
      end
      chk("status", {67'h0, 2'b00, (c[1:0] == 2'h3) ? (c[2] ? 3'h4 : 3'h3) : {1'b0, c[1:0]}}, {67'h0, status});
    end
    repeat (10) @(posedge clk);
    chk("step_count", {56'h0, 16'(total)}, {56'h0, step_count});
    tally_and_finish();
  end
endmodule // testbench
